/* rtl/prsd_params.svh */
// Offsets, reset values, masks and timing counts of the protection status and debug registers.
`ifndef PRSD_PARAMS_SVH
`define PRSD_PARAMS_SVH
`define PRSD_OFS_CAPS 8'hA0
`define PRSD_OFS_COUNT 8'hA1
`define PRSD_OFS_DEPTH 8'hA2
`define PRSD_OFS_KEYLIST 8'hA3
`define PRSD_OFS_DEBUG 8'hC0
`define PRSD_RST_CAPS 8'h13
`define PRSD_RST_COUNT 8'h00
`define PRSD_RST_DEPTH 8'h00
`define PRSD_RST_KEYLIST 8'h00
`define PRSD_RST_DEBUG 8'h00
`define PRSD_MASK_CAPS 8'h73
`define PRSD_MASK_COUNT 8'hFF
`define PRSD_MASK_DEPTH 8'h0F
`define PRSD_MASK_DEBUG 8'h0F
`define PRSD_BIT_REPEATER 6
`define PRSD_BIT_LIST_READY 5
`define PRSD_BIT_FAST_I2C 4
`define PRSD_BIT_FEATURES 1
`define PRSD_BIT_REAUTH 0
`define PRSD_BIT_MAX_DEV 7
`define PRSD_BIT_MAX_CASCADE 3
`define PRSD_BIT_CHECKSUM 3
`define PRSD_BIT_FAST_VERIFY 2
`define PRSD_BIT_SPEEDUP 1
`define PRSD_BIT_I2C_FAST 0
`define PRSD_FV_FAST_MASK 7'h01
`define PRSD_FV_SLOW_MASK 7'h0F
`define PRSD_LI_FAST_MASK 7'h0F
`define PRSD_LI_SLOW_MASK 7'h7F
`endif

/* rtl/prsd_pkg.sv */
// Types shared by the protection status and debug register bank.
package prsd_pkg;
  typedef struct packed {
    logic [7:0] caps;
    logic [7:0] count;
    logic [7:0] depth;
    logic [7:0] keylist;
    logic [7:0] debug;
    logic [7:0] rdata;
    logic rvalid;
    logic kl_next;
    logic [6:0] frames;
    logic fv_strobe;
    logic li_strobe;
    logic in_line;
    logic [7:0] sum_r;
    logic [7:0] sum_g;
    logic [7:0] sum_b;
    logic ck_valid;
    logic [7:0] ck_r;
    logic [7:0] ck_g;
    logic [7:0] ck_b;
  } prsd_state_t;
endpackage : prsd_pkg

/* rtl/prsd_regs.sv */
// Receiver status mirror and content protection debug register bank.
`timescale 1ns/10ps
`include "prsd_params.svh"

module prsd_regs (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic bc_caps_we,
  input wire logic [7:0] bc_caps,
  input wire logic bc_count_we,
  input wire logic [7:0] bc_count,
  input wire logic bc_depth_we,
  input wire logic [7:0] bc_depth,
  input wire logic bc_key_we,
  input wire logic [7:0] bc_key_byte,
  output logic key_list_next,
  input wire logic key_vector_ready,
  input wire logic frame_start,
  input wire logic video_de,
  input wire logic [7:0] video_r,
  input wire logic [7:0] video_g,
  input wire logic [7:0] video_b,
  output logic line_checksum_enable,
  output logic fast_verify_enable,
  output logic timer_speedup,
  output logic remote_master_fast_mode,
  output logic indirect_status_fast,
  output logic frame_verify_strobe,
  output logic link_integrity_strobe,
  output logic checksum_valid,
  output logic [7:0] checksum_r,
  output logic [7:0] checksum_g,
  output logic [7:0] checksum_b
);

  prsd_pkg::prsd_state_t s_q;
  prsd_pkg::prsd_state_t s_d;
  logic [7:0] rd_mux;
  logic [6:0] fv_mask;
  logic [6:0] li_mask;
  logic line_end;

  // End-around carry keeps the sum a true ones-complement total.
  function automatic logic [7:0] prsd_oc_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0] + {7'h00, s[8]};
  endfunction : prsd_oc_add

  assign line_end = s_q.in_line && !video_de;
  assign fv_mask = s_q.debug[`PRSD_BIT_FAST_VERIFY] ? `PRSD_FV_FAST_MASK : `PRSD_FV_SLOW_MASK;
  assign li_mask = s_q.debug[`PRSD_BIT_FAST_VERIFY] ? `PRSD_LI_FAST_MASK : `PRSD_LI_SLOW_MASK;

  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      `PRSD_OFS_CAPS: begin
        rd_mux = s_q.caps;
        // The repeater bit means nothing before the key vector is in.
        rd_mux[`PRSD_BIT_REPEATER] = s_q.caps[`PRSD_BIT_REPEATER] & key_vector_ready;
      end
      `PRSD_OFS_COUNT: begin
        rd_mux = s_q.count;
        if (!s_q.caps[`PRSD_BIT_REPEATER]) begin
          rd_mux[6:0] = 7'h00;
        end
      end
      `PRSD_OFS_DEPTH: rd_mux = s_q.depth;
      `PRSD_OFS_KEYLIST: rd_mux = s_q.keylist;
      `PRSD_OFS_DEBUG: rd_mux = s_q.debug;
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.rvalid = reg_rd;
    s_d.kl_next = 1'b0;
    s_d.fv_strobe = 1'b0;
    s_d.li_strobe = 1'b0;
    s_d.ck_valid = 1'b0;
    if (reg_rd) begin
      s_d.rdata = rd_mux;
      s_d.kl_next = (reg_addr == `PRSD_OFS_KEYLIST);
    end
    // Host writes reach only the debug register; the mirror is refreshed by the link.
    if (reg_wr && reg_addr == `PRSD_OFS_DEBUG) begin
      s_d.debug = reg_wdata & `PRSD_MASK_DEBUG;
    end
    if (bc_caps_we) begin
      s_d.caps = bc_caps & `PRSD_MASK_CAPS;
    end
    if (bc_count_we) begin
      s_d.count = bc_count & `PRSD_MASK_COUNT;
    end
    if (bc_depth_we) begin
      s_d.depth = bc_depth & `PRSD_MASK_DEPTH;
    end
    if (bc_key_we) begin
      s_d.keylist = bc_key_byte;
    end
    if (frame_start) begin
      s_d.frames = s_q.frames + 7'h01;
      s_d.fv_strobe = ((s_q.frames & fv_mask) == fv_mask);
      s_d.li_strobe = ((s_q.frames & li_mask) == li_mask);
    end
    s_d.in_line = video_de;
    if (video_de) begin
      s_d.sum_r = prsd_oc_add(s_q.sum_r, video_r);
      s_d.sum_g = prsd_oc_add(s_q.sum_g, video_g);
      s_d.sum_b = prsd_oc_add(s_q.sum_b, video_b);
    end else if (line_end) begin
      s_d.sum_r = 8'h00;
      s_d.sum_g = 8'h00;
      s_d.sum_b = 8'h00;
      if (s_q.debug[`PRSD_BIT_CHECKSUM]) begin
        s_d.ck_valid = 1'b1;
        s_d.ck_r = ~s_q.sum_r;
        s_d.ck_g = ~s_q.sum_g;
        s_d.ck_b = ~s_q.sum_b;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.caps <= `PRSD_RST_CAPS;
      s_q.count <= `PRSD_RST_COUNT;
      s_q.depth <= `PRSD_RST_DEPTH;
      s_q.keylist <= `PRSD_RST_KEYLIST;
      s_q.debug <= `PRSD_RST_DEBUG;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign reg_rvalid = s_q.rvalid;
  assign key_list_next = s_q.kl_next;
  assign line_checksum_enable = s_q.debug[`PRSD_BIT_CHECKSUM];
  assign fast_verify_enable = s_q.debug[`PRSD_BIT_FAST_VERIFY];
  assign timer_speedup = s_q.debug[`PRSD_BIT_SPEEDUP];
  assign remote_master_fast_mode = s_q.debug[`PRSD_BIT_I2C_FAST];
  assign indirect_status_fast = s_q.debug[`PRSD_BIT_I2C_FAST];
  assign frame_verify_strobe = s_q.fv_strobe;
  assign link_integrity_strobe = s_q.li_strobe;
  assign checksum_valid = s_q.ck_valid;
  assign checksum_r = s_q.ck_r;
  assign checksum_g = s_q.ck_g;
  assign checksum_b = s_q.ck_b;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  property p_rep_gate;
    reg_rd && reg_addr == `PRSD_OFS_CAPS && !key_vector_ready |=> reg_rvalid && !reg_rdata[6];
  endproperty
  a_rep_gate: assert property (p_rep_gate) else $error("Repeater bit shown before ready.");

  property p_caps_res;
    reg_rd && reg_addr == `PRSD_OFS_CAPS |=> reg_rdata[7] == 1'b0 && reg_rdata[3:2] == 2'b00;
  endproperty
  a_caps_res: assert property (p_caps_res) else $error("Reserved capability bit set.");

  property p_caps_src;
    bc_caps_we ##1 !bc_caps_we ##1 reg_rd && reg_addr == `PRSD_OFS_CAPS && key_vector_ready
      && !bc_caps_we |=> reg_rdata == ($past(bc_caps, 3) & `PRSD_MASK_CAPS);
  endproperty
  a_caps_src: assert property (p_caps_src) else $error("Capabilities not from link.");

  property p_count_zero;
    reg_rd && reg_addr == `PRSD_OFS_COUNT && !s_q.caps[6] |=> reg_rdata[6:0] == 7'h00;
  endproperty
  a_count_zero: assert property (p_count_zero) else $error("Count nonzero for receiver.");

  property p_depth_res;
    reg_rd && reg_addr == `PRSD_OFS_DEPTH |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_depth_res: assert property (p_depth_res) else $error("Depth reserved bits set.");

  // Back-to-back key list reads legally keep the request high, so only a read with no key list read in the next cycle is checked.
  property p_kl_next;
    reg_rd && reg_addr == `PRSD_OFS_KEYLIST ##1 !(reg_rd && reg_addr == `PRSD_OFS_KEYLIST)
      |-> key_list_next ##1 !key_list_next;
  endproperty
  a_kl_next: assert property (p_kl_next) else $error("Key list did not advance once.");

  property p_dbg_wr;
    reg_wr && reg_addr == `PRSD_OFS_DEBUG |=> timer_speedup == $past(reg_wdata[1])
      && indirect_status_fast == $past(reg_wdata[0])
      && remote_master_fast_mode == $past(reg_wdata[0]);
  endproperty
  a_dbg_wr: assert property (p_dbg_wr) else $error("Debug write not applied.");

  property p_fv_fast;
    fast_verify_enable && frame_start && s_q.frames[0] |=> frame_verify_strobe;
  endproperty
  a_fv_fast: assert property (p_fv_fast) else $error("Fast frame verify missed.");

  property p_li_slow;
    !fast_verify_enable && frame_start && s_q.frames[3:0] == 4'hF && s_q.frames[6:4] != 3'h7
      |=> frame_verify_strobe && !link_integrity_strobe;
  endproperty
  a_li_slow: assert property (p_li_slow) else $error("Slow link check rate wrong.");

  property p_ck;
    line_checksum_enable && line_end |=> checksum_valid ##1 !checksum_valid;
  endproperty
  a_ck: assert property (p_ck) else $error("Line checksum not sent.");

  property p_ck_off;
    !line_checksum_enable |=> !checksum_valid;
  endproperty
  a_ck_off: assert property (p_ck_off) else $error("Checksum sent while disabled.");

  property p_rd_answer;
    reg_rd |=> reg_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("Read not answered.");

  property p_rd_quiet;
    !reg_rd |=> !reg_rvalid;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("Read valid without a read.");

  property p_dbg_res;
    reg_rd && reg_addr == `PRSD_OFS_DEBUG |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_dbg_res: assert property (p_dbg_res) else $error("Debug reserved bits set.");

  property p_unmapped;
    reg_rd && !(reg_addr inside {`PRSD_OFS_CAPS, `PRSD_OFS_COUNT, `PRSD_OFS_DEPTH,
      `PRSD_OFS_KEYLIST, `PRSD_OFS_DEBUG}) |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped read not zero.");

  property p_max_dev;
    reg_rd && reg_addr == `PRSD_OFS_COUNT |=> reg_rdata[7] == $past(s_q.count[7]);
  endproperty
  a_max_dev: assert property (p_max_dev) else $error("Device overflow flag lost.");

  property p_count_src;
    bc_count_we |=> s_q.count == $past(bc_count);
  endproperty
  a_count_src: assert property (p_count_src) else $error("Device count not from link.");

  property p_depth_src;
    bc_depth_we |=> s_q.depth == ($past(bc_depth) & `PRSD_MASK_DEPTH);
  endproperty
  a_depth_src: assert property (p_depth_src) else $error("Depth not from link.");

  property p_features;
    bc_caps_we |=> s_q.caps[5:4] == $past(bc_caps[5:4]) && s_q.caps[1:0] == $past(bc_caps[1:0]);
  endproperty
  a_features: assert property (p_features) else $error("Capability bits lost.");

  // A host write must never disturb what the back channel reported.
  property p_host_ro;
    reg_wr && reg_addr != `PRSD_OFS_DEBUG && !bc_caps_we && !bc_count_we && !bc_depth_we
      |=> $stable(s_q.caps) && $stable(s_q.count) && $stable(s_q.depth);
  endproperty
  a_host_ro: assert property (p_host_ro) else $error("Host wrote a mirror register.");

  property p_li_fast;
    fast_verify_enable && frame_start && s_q.frames[3:0] == 4'hF |=> link_integrity_strobe;
  endproperty
  a_li_fast: assert property (p_li_fast) else $error("Fast link check missed.");

  property p_fv_slow;
    !fast_verify_enable && frame_start && s_q.frames[3:0] != 4'hF |=> !frame_verify_strobe;
  endproperty
  a_fv_slow: assert property (p_fv_slow) else $error("Slow frame verify too often.");

  c_kl_read: cover property (reg_rd && reg_addr == `PRSD_OFS_KEYLIST ##1 key_list_next);
  c_li_fast: cover property (fast_verify_enable && link_integrity_strobe);
  c_ck_line: cover property (checksum_valid);
  c_rep_cnt: cover property (reg_rd && reg_addr == `PRSD_OFS_COUNT && s_q.caps[6]);
  c_fv_slow: cover property (!fast_verify_enable && frame_verify_strobe);

endmodule : prsd_regs

/* test/prsd_bc_model.sv */
// Back-channel model that refills the key list read port after each host key list read made while no refill is under way.
`timescale 1ns/10ps
module prsd_bc_model (
  input wire logic clock,
  input wire logic key_list_next,
  output logic bc_key_we,
  output logic [7:0] bc_key_byte
);
  logic [7:0] n_q = 8'h00;
  initial begin
    bc_key_we = 1'b0;
    bc_key_byte = 8'h00;
  end
  // The refill lags by a cycle, as a slow link would, and the data line is spoiled afterwards.
  always @(posedge clock) begin
    if (key_list_next === 1'b1) begin
      @(posedge clock);
      bc_key_we <= 1'b1;
      bc_key_byte <= 8'h5A + n_q;
      n_q <= n_q + 8'h01;
      @(posedge clock);
      bc_key_we <= 1'b0;
      bc_key_byte <= ~bc_key_byte;
    end
  end
endmodule : prsd_bc_model

/* test/testbench.sv */
// Self-checking bench for the protection status and debug register bank.
`timescale 1ns/10ps
module testbench;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, bc_caps = 8'h00;
  logic [7:0] bc_count = 8'h00, bc_depth = 8'h00, bc_key_byte;
  logic [7:0] video_r = 8'h00, video_g = 8'h00, video_b = 8'h00;
  logic [7:0] checksum_r, checksum_g, checksum_b, fv_n = 8'h00, li_n = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid, bc_caps_we = 1'b0, bc_count_we = 1'b0;
  logic bc_depth_we = 1'b0, bc_key_we, key_list_next, key_vector_ready = 1'b0;
  logic frame_start = 1'b0, video_de = 1'b0, line_checksum_enable, fast_verify_enable;
  logic timer_speedup, remote_master_fast_mode, indirect_status_fast;
  logic frame_verify_strobe, link_integrity_strobe, checksum_valid;
  int fail_count = 0, comparisons = 0;
  logic [7:0] row_a[6] = '{8'hC0, 8'hC0, 8'hA0, 8'hA1, 8'h55, 8'hC0};
  logic [7:0] row_w[6] = '{8'hFF, 8'h05, 8'hFF, 8'hFF, 8'hFF, 8'h00};
  logic [7:0] row_e[6] = '{8'h0F, 8'h05, 8'h13, 8'h00, 8'h00, 8'h00};

  prsd_regs dut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .bc_caps_we(bc_caps_we), .bc_caps(bc_caps), .bc_count_we(bc_count_we),
    .bc_count(bc_count), .bc_depth_we(bc_depth_we), .bc_depth(bc_depth),
    .bc_key_we(bc_key_we), .bc_key_byte(bc_key_byte), .key_list_next(key_list_next),
    .key_vector_ready(key_vector_ready), .frame_start(frame_start), .video_de(video_de),
    .video_r(video_r), .video_g(video_g), .video_b(video_b),
    .line_checksum_enable(line_checksum_enable), .fast_verify_enable(fast_verify_enable),
    .timer_speedup(timer_speedup), .remote_master_fast_mode(remote_master_fast_mode),
    .indirect_status_fast(indirect_status_fast), .frame_verify_strobe(frame_verify_strobe),
    .link_integrity_strobe(link_integrity_strobe), .checksum_valid(checksum_valid),
    .checksum_r(checksum_r), .checksum_g(checksum_g), .checksum_b(checksum_b));
  prsd_bc_model model (.clock(clock), .key_list_next(key_list_next), .bc_key_we(bc_key_we),
    .bc_key_byte(bc_key_byte));

  always #10 clock = ~clock;
  always @(posedge clock) begin
    fv_n <= fv_n + {7'h00, frame_verify_strobe === 1'b1};
    li_n <= li_n + {7'h00, link_integrity_strobe === 1'b1};
  end

  task chk(input string name, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk("read valid", 8'h01, {7'h00, reg_rvalid});
    chk("read data", e, reg_rdata);
  endtask : rd
  task bcw(input logic [2:0] sel, input logic [7:0] v);
    @(posedge clock);
    {bc_caps_we, bc_count_we, bc_depth_we} <= sel;
    {bc_caps, bc_count, bc_depth} <= {v, v, v};
    @(posedge clock);
    {bc_caps_we, bc_count_we, bc_depth_we} <= 3'b000;
    {bc_caps, bc_count, bc_depth} <= ~{v, v, v};
  endtask : bcw
  task frames(input int n);
    #1;
    fv_n = 8'h00;
    li_n = 8'h00;
    repeat (n) begin
      @(posedge clock);
      frame_start <= 1'b1;
      @(posedge clock);
      frame_start <= 1'b0;
    end
    repeat (3) @(posedge clock);
  endtask : frames
  task stop_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    #(3000 * 20);
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    rd(8'hA0, 8'h13);
    rd(8'hA2, 8'h00);
    rd(8'hA3, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(row_a[i], row_w[i]);
      rd(row_a[i], row_e[i]);
    end
    wr(8'hC0, 8'h0F);
    #1;
    chk("debug outs", 8'h0F, {4'h0, line_checksum_enable, fast_verify_enable, timer_speedup,
      remote_master_fast_mode});
    chk("mirror", 8'h01, {7'h00, indirect_status_fast});
    bcw(3'b100, 8'hFF);
    rd(8'hA0, 8'h33);
    @(posedge clock);
    key_vector_ready <= 1'b1;
    rd(8'hA0, 8'h73);
    bcw(3'b010, 8'hFF);
    rd(8'hA1, 8'hFF);
    bcw(3'b100, 8'h00);
    rd(8'hA0, 8'h00);
    rd(8'hA1, 8'h80);
    bcw(3'b001, 8'hFF);
    rd(8'hA2, 8'h0F);
    rd(8'hA3, 8'h5A);
    repeat (4) @(posedge clock);
    rd(8'hA3, 8'h5B);
    wr(8'hC0, 8'h04);
    frames(16);
    chk("fast frame", 8'h08, fv_n);
    chk("fast link", 8'h01, li_n);
    wr(8'hC0, 8'h08);
    frames(128);
    chk("slow frame", 8'h08, fv_n);
    chk("slow link", 8'h01, li_n);
    video_de <= 1'b1;
    {video_r, video_g, video_b} <= {8'h01, 8'h10, 8'hFF};
    @(posedge clock);
    video_r <= 8'h02;
    @(posedge clock);
    video_de <= 1'b0;
    @(posedge clock);
    #1;
    chk("sum valid", 8'h01, {7'h00, checksum_valid});
    chk("sum r", 8'hFC, checksum_r);
    chk("sum g", 8'hDF, checksum_g);
    chk("sum b", 8'h00, checksum_b);
    @(posedge clock);
    #1;
    chk("sum done", 8'h00, {7'h00, checksum_valid});
    @(posedge clock);
    rst_b <= 1'b0;
    @(posedge clock);
    rst_b <= 1'b1;
    #1;
    chk("reset outs", 8'h00, {line_checksum_enable, fast_verify_enable, timer_speedup,
      remote_master_fast_mode, indirect_status_fast, frame_verify_strobe, checksum_valid,
      reg_rvalid});
    rd(8'hC0, 8'h00);
    rd(8'hA0, 8'h13);
    stop_test();
  end
endmodule : testbench
